/* shared/rgpc_pkg.sv */
// constants and types for the receiver global power and reset control block
// ----------------------------------------------------------------------------
// Contract
// - revision code read-only, upper byte at 0xEA, lower byte at 0xEB.
// - main sleep bit 1 powers chip down; resets to 1.
// - processing-core clock-off bit stops core clock; receiver and sync detect run.
// - crystal gate removes crystal clock from detectors, sequencer, core, receiver.
// - core gate stops non-crystal clocks to core and receiver digital; resets 0.
// - sleep=1 gives mode 0 or 1 by keep-alive bit; sleep=0 normal.
// - normal mode follows keep-alive and port EDID enables; low power keeps EDID.
// - mode 0 disables all except I2C slave, EDID controller, ring oscillator.
// - ring oscillator clocks EDID controller and supply filter in low power.
// - mode 0 keeps only I2C, supply detect, hotplug, DDC and reset pads.
// - mode 1 adds crystal clock, consumer control, interrupts and their pads.
// - low-power modes keep internal EDID readable over DDC on both ports.
// - writing 1 to defaults reset bit restores all registers; bit reads 0.
// - output-pad power-down tristates and blocks inputs of sync, int, clock, pixels.
// - display-channel pad power-down turns off all DDC pads of both ports.
// - pixel bus tristate bit floats 36 pixel outputs; resets to 1.
// - pixel clock tristate bit floats pixel clock output; resets to 1.
// - sync tristate bit floats HS, vsync/field and DE; resets to 1.
// - audio tristate bit floats six audio pins, bit and master clock; resets 1.
// - tristating only through register bits, no dedicated pin.
// ----------------------------------------------------------------------------
package rgpc_pkg;
    localparam logic [7:0] RGPC_ADDR_CLKGATE = 8'h0B;
    localparam logic [7:0] RGPC_ADDR_POWER   = 8'h0C;
    localparam logic [7:0] RGPC_ADDR_HIZ     = 8'h15;
    localparam logic [7:0] RGPC_ADDR_DDC     = 8'h73;
    localparam logic [7:0] RGPC_ADDR_REV_HI  = 8'hEA;
    localparam logic [7:0] RGPC_ADDR_REV_LO  = 8'hEB;
    localparam logic [7:0] RGPC_ADDR_RESET   = 8'hFF;
    localparam logic [7:0] RGPC_ADDR_CEC     = 8'h10;
    localparam logic [7:0] RGPC_ADDR_STATUS  = 8'h11;

    localparam int RGPC_BIT_XTAL_GATE  = 0;
    localparam int RGPC_BIT_CORE_GATE  = 1;
    localparam int RGPC_BIT_PADS_OFF   = 0;
    localparam int RGPC_BIT_PROC_OFF   = 2;
    localparam int RGPC_BIT_SLEEP      = 5;
    localparam int RGPC_BIT_PIX_HIZ    = 1;
    localparam int RGPC_BIT_PCLK_HIZ   = 2;
    localparam int RGPC_BIT_SYNC_HIZ   = 3;
    localparam int RGPC_BIT_AUDIO_HIZ  = 4;
    localparam int RGPC_BIT_DDC_OFF    = 0;
    localparam int RGPC_BIT_DEFAULTS   = 7;
    localparam int RGPC_BIT_KEEP_ALIVE = 0;

    localparam logic RGPC_RST_XTAL_GATE  = 1'h0;
    localparam logic RGPC_RST_CORE_GATE  = 1'h0;
    localparam logic RGPC_RST_PADS_OFF   = 1'h0;
    localparam logic RGPC_RST_PROC_OFF   = 1'h0;
    localparam logic RGPC_RST_SLEEP      = 1'h1;
    localparam logic RGPC_RST_HIZ        = 1'h1;
    localparam logic RGPC_RST_DDC_OFF    = 1'h0;
    localparam logic RGPC_RST_KEEP_ALIVE = 1'h0;

    // arbitrary neutral identification value
    localparam logic [15:0] RGPC_REVISION_DEFAULT = 16'h5A01;

    localparam int RGPC_PIX_WIDTH   = 36;
    localparam int RGPC_AUDIO_WIDTH = 8;

    typedef enum logic [1:0] {
        RGPC_MODE_NORMAL = 2'b00,
        RGPC_MODE_LOW0   = 2'b01,
        RGPC_MODE_LOW1   = 2'b10
    } rgpc_mode_t;
endpackage

/* core/rgpc_global_ctrl.sv */
// global power-down, reset and tristate control of the dual-port receiver
`timescale 1ns/1ns
module rgpc_global_ctrl
    import rgpc_pkg::*;
#(
    parameter logic [15:0] REVISION   = RGPC_REVISION_DEFAULT,
    parameter int          PIX_WIDTH  = RGPC_PIX_WIDTH,
    parameter int          AUD_WIDTH  = RGPC_AUDIO_WIDTH
) (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic                      reg_hit,
    input  wire logic                 port_edid_enable_a,
    input  wire logic                 port_edid_enable_b,
    output logic      [1:0]           power_mode,
    output logic                      proc_core_clk_en,
    output logic                      receiver_digital_clk_en,
    output logic                      sync_detect_clk_en,
    output logic                      crystal_to_core_en,
    output logic                      crystal_to_edid_en,
    output logic                      consumer_control_en,
    output logic                      interrupt_ctrl_en,
    output logic                      ring_osc_en,
    output logic                      edid_en_a,
    output logic                      edid_en_b,
    output logic                      consumer_control_pad_en,
    output logic                      interrupt_pads_en,
    output logic                      ddc_pads_en,
    output logic [PIX_WIDTH-1:0]      pixel_oe,
    output logic                      pixel_in_en,
    output logic                      pixel_clock_out_oe,
    output logic                      sync_oe,
    output logic                      sync_in_en,
    output logic                      first_interrupt_pin_oe,
    output logic [AUD_WIDTH-1:0]      audio_oe
);

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    logic xtal_gate_q;
    logic core_gate_q;
    logic pads_off_q;
    logic proc_off_q;
    logic sleep_q;
    logic pix_hiz_q;
    logic pclk_hiz_q;
    logic sync_hiz_q;
    logic audio_hiz_q;
    logic ddc_off_q;
    logic keep_alive_q;
    logic defaults_q;

    function automatic logic wr_hit(input logic [7:0] a);
        return reg_wr_en && (reg_addr == a);
    endfunction

    // defaults reset is a pulse one cycle after the write; it restores every
    // register and then reads back as 0
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            defaults_q <= 1'h0;
        end else begin
            defaults_q <= wr_hit(RGPC_ADDR_RESET) && reg_wdata[RGPC_BIT_DEFAULTS];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            xtal_gate_q <= RGPC_RST_XTAL_GATE;
            core_gate_q <= RGPC_RST_CORE_GATE;
        end else if (defaults_q) begin
            xtal_gate_q <= RGPC_RST_XTAL_GATE;
            core_gate_q <= RGPC_RST_CORE_GATE;
        end else if (wr_hit(RGPC_ADDR_CLKGATE)) begin
            xtal_gate_q <= reg_wdata[RGPC_BIT_XTAL_GATE];
            core_gate_q <= reg_wdata[RGPC_BIT_CORE_GATE];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pads_off_q <= RGPC_RST_PADS_OFF;
            proc_off_q <= RGPC_RST_PROC_OFF;
            sleep_q    <= RGPC_RST_SLEEP;
        end else if (defaults_q) begin
            pads_off_q <= RGPC_RST_PADS_OFF;
            proc_off_q <= RGPC_RST_PROC_OFF;
            sleep_q    <= RGPC_RST_SLEEP;
        end else if (wr_hit(RGPC_ADDR_POWER)) begin
            pads_off_q <= reg_wdata[RGPC_BIT_PADS_OFF];
            proc_off_q <= reg_wdata[RGPC_BIT_PROC_OFF];
            sleep_q    <= reg_wdata[RGPC_BIT_SLEEP];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pix_hiz_q   <= RGPC_RST_HIZ;
            pclk_hiz_q  <= RGPC_RST_HIZ;
            sync_hiz_q  <= RGPC_RST_HIZ;
            audio_hiz_q <= RGPC_RST_HIZ;
        end else if (defaults_q) begin
            pix_hiz_q   <= RGPC_RST_HIZ;
            pclk_hiz_q  <= RGPC_RST_HIZ;
            sync_hiz_q  <= RGPC_RST_HIZ;
            audio_hiz_q <= RGPC_RST_HIZ;
        end else if (wr_hit(RGPC_ADDR_HIZ)) begin
            // tristate bits are written by the host only here, no pin overrides them
            pix_hiz_q   <= reg_wdata[RGPC_BIT_PIX_HIZ];
            pclk_hiz_q  <= reg_wdata[RGPC_BIT_PCLK_HIZ];
            sync_hiz_q  <= reg_wdata[RGPC_BIT_SYNC_HIZ];
            audio_hiz_q <= reg_wdata[RGPC_BIT_AUDIO_HIZ];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ddc_off_q    <= RGPC_RST_DDC_OFF;
            keep_alive_q <= RGPC_RST_KEEP_ALIVE;
        end else if (defaults_q) begin
            ddc_off_q    <= RGPC_RST_DDC_OFF;
            keep_alive_q <= RGPC_RST_KEEP_ALIVE;
        end else begin
            if (wr_hit(RGPC_ADDR_DDC)) begin
                ddc_off_q <= reg_wdata[RGPC_BIT_DDC_OFF];
            end
            if (wr_hit(RGPC_ADDR_CEC)) begin
                keep_alive_q <= reg_wdata[RGPC_BIT_KEEP_ALIVE];
            end
        end
    end

    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    rgpc_mode_t mode;
    logic       low_power;
    logic       awake;
    logic       keep_mode1;

    always_comb begin
        case ({sleep_q, keep_alive_q})
            2'h2:    mode = RGPC_MODE_LOW0;
            2'h3:    mode = RGPC_MODE_LOW1;
            2'h0:    mode = RGPC_MODE_NORMAL;
            2'h1:    mode = RGPC_MODE_NORMAL;
            default: mode = RGPC_MODE_LOW0;
        endcase
    end

    assign low_power  = (mode != RGPC_MODE_NORMAL);
    assign awake      = (mode == RGPC_MODE_NORMAL);
    assign keep_mode1 = (mode == RGPC_MODE_LOW1);
    assign power_mode = mode;

    // ------------------------------------------------------------------------
    // clock and section enables, combinational so a write acts at once
    // ------------------------------------------------------------------------
    assign proc_core_clk_en        = awake && !proc_off_q && !core_gate_q;
    assign receiver_digital_clk_en = awake && !core_gate_q;
    assign sync_detect_clk_en      = awake && !xtal_gate_q;
    assign crystal_to_core_en      = awake && !xtal_gate_q;
    assign crystal_to_edid_en      = awake || keep_mode1;
    assign consumer_control_en     = keep_alive_q;
    assign interrupt_ctrl_en       = awake || keep_mode1;
    assign ring_osc_en             = low_power;
    assign edid_en_a               = low_power || port_edid_enable_a;
    assign edid_en_b               = low_power || port_edid_enable_b;

    // ------------------------------------------------------------------------
    // pad enables
    // ------------------------------------------------------------------------
    assign consumer_control_pad_en = awake || keep_mode1;
    assign interrupt_pads_en       = awake || keep_mode1;
    // ddc pads follow only the DDC pad power-down bit, not the mode, so low power alone leaves EDID reachable
    assign ddc_pads_en             = !ddc_off_q;
    assign pixel_oe                = {PIX_WIDTH{awake && !pads_off_q && !pix_hiz_q}};
    assign pixel_in_en             = awake && !pads_off_q;
    assign pixel_clock_out_oe      = awake && !pads_off_q && !pclk_hiz_q;
    assign sync_oe                 = awake && !pads_off_q && !sync_hiz_q;
    assign sync_in_en              = awake && !pads_off_q;
    assign first_interrupt_pin_oe  = (awake || keep_mode1) && !pads_off_q;
    assign audio_oe                = {AUD_WIDTH{awake && !audio_hiz_q}};

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    logic [7:0] rd_d;
    logic       hit_d;

    always_comb begin
        rd_d  = 8'h00;
        hit_d = 1'h1;
        case (reg_addr)
            RGPC_ADDR_CLKGATE: begin
                rd_d[RGPC_BIT_XTAL_GATE] = xtal_gate_q;
                rd_d[RGPC_BIT_CORE_GATE] = core_gate_q;
            end
            RGPC_ADDR_POWER: begin
                rd_d[RGPC_BIT_PADS_OFF] = pads_off_q;
                rd_d[RGPC_BIT_PROC_OFF] = proc_off_q;
                rd_d[RGPC_BIT_SLEEP]    = sleep_q;
            end
            RGPC_ADDR_HIZ: begin
                rd_d[RGPC_BIT_PIX_HIZ]   = pix_hiz_q;
                rd_d[RGPC_BIT_PCLK_HIZ]  = pclk_hiz_q;
                rd_d[RGPC_BIT_SYNC_HIZ]  = sync_hiz_q;
                rd_d[RGPC_BIT_AUDIO_HIZ] = audio_hiz_q;
            end
            RGPC_ADDR_DDC:    rd_d[RGPC_BIT_DDC_OFF] = ddc_off_q;
            RGPC_ADDR_CEC:    rd_d[RGPC_BIT_KEEP_ALIVE] = keep_alive_q;
            RGPC_ADDR_STATUS: rd_d[1:0] = mode;
            RGPC_ADDR_REV_HI: rd_d = REVISION[15:8];
            RGPC_ADDR_REV_LO: rd_d = REVISION[7:0];
            RGPC_ADDR_RESET:  rd_d = 8'h00;
            default:          hit_d = 1'h0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'h0;
        end else if (reg_rd_en) begin
            reg_rdata <= rd_d;
            reg_hit   <= hit_d;
        end
    end

endmodule

/* sim/rgpc_ctrl_monitor.sv */
// concurrent checks on the ports of the global power and reset control block
`timescale 1ns/1ns
module rgpc_ctrl_monitor #(
    parameter logic [15:0] REVISION = 16'h0000
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    input wire logic [1:0]  power_mode,
    input wire logic [35:0] pixel_oe,
    input wire logic        pixel_in_en,
    input wire logic        pixel_clock_out_oe,
    input wire logic        sync_oe,
    input wire logic        first_interrupt_pin_oe,
    input wire logic [7:0]  audio_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire w0c = reg_wr_en && reg_addr == 8'h0C;
    wire w15 = reg_wr_en && reg_addr == 8'h15;
    property p_rev; reg_rd_en && reg_addr[7:1] == 7'h75 |=> reg_hit
        && reg_rdata == ($past(reg_addr) == 8'hEA ? REVISION[15:8] : REVISION[7:0]); endproperty
    a_rev: assert property (p_rev) else $error("bad revision read");
    property p_wake; w0c && !reg_wdata[5] |=> power_mode == 2'h0; endproperty
    a_wake: assert property (p_wake) else $error("not awake");
    property p_sleep; w0c && reg_wdata[5] |=> power_mode != 2'h0 && pixel_oe == '0; endproperty
    a_sleep: assert property (p_sleep) else $error("not asleep");
    property p_pads; w0c && reg_wdata[0] |=> pixel_oe == '0 && !pixel_in_en && !sync_oe
        && !pixel_clock_out_oe && !first_interrupt_pin_oe; endproperty
    a_pads: assert property (p_pads) else $error("pads still on");
    property p_pix; w15 && reg_wdata[1] |=> pixel_oe == '0; endproperty
    a_pix: assert property (p_pix) else $error("pixel bus driven");
    property p_clk; w15 && reg_wdata[2] |=> !pixel_clock_out_oe; endproperty
    a_clk: assert property (p_clk) else $error("pixel clock driven");
    property p_sync; w15 && reg_wdata[3] |=> !sync_oe; endproperty
    a_sync: assert property (p_sync) else $error("sync driven");
    property p_aud; w15 && reg_wdata[4] |=> audio_oe == '0; endproperty
    a_aud: assert property (p_aud) else $error("audio driven");
    // restore lands one edge after the strobe, so look two edges on
    property p_def; reg_wr_en && reg_addr == 8'hFF && reg_wdata[7]
        |-> ##2 power_mode == 2'h1 && audio_oe == '0; endproperty
    a_def: assert property (p_def) else $error("defaults not restored");
endmodule
bind rgpc_global_ctrl rgpc_ctrl_monitor #(.REVISION(REVISION)) u_mon (.*);

/* sim/rgpc_host_model.sv */
// host model issuing register accesses as the control-port slave would
`timescale 1ns/1ns
module rgpc_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_hit,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // one-cycle strobe; r returns {hit, read data} taken after the strobe edge
    task automatic xfer(input logic w, input logic [7:0] a, v, output logic [8:0] r);
        @(posedge clk_sys);
        #1;
        reg_wr_en = w;
        reg_rd_en = !w;
        reg_addr  = a;
        reg_wdata = v;
        @(posedge clk_sys);
        #1;
        r = {reg_hit, reg_rdata};
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
        // flipped so a stale value is never mistaken for a held one
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the global power and reset control block
`timescale 1ns/1ns
module tb;
    localparam logic [15:0] REV = 16'hC3A5; // arbitrary revision value
    logic        clk_sys, sys_rst, reg_wr_en, reg_rd_en, reg_hit, pixel_in_en, sync_in_en;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, audio_oe;
    logic [1:0]  power_mode;
    logic [35:0] pixel_oe;
    logic [8:0]  rr;
    logic        port_edid_enable_a, port_edid_enable_b, edid_en_a, edid_en_b, ddc_pads_en;
    logic        proc_core_clk_en, receiver_digital_clk_en, sync_detect_clk_en, ring_osc_en;
    logic        crystal_to_core_en, crystal_to_edid_en, consumer_control_en, interrupt_ctrl_en;
    logic        consumer_control_pad_en, interrupt_pads_en, pixel_clock_out_oe, sync_oe;
    logic        first_interrupt_pin_oe, sl, ka, pd, pr, cg, xg, dc;
    logic [3:0]  hz;
    int          err_count = 0;
    int          total_checks = 0;
    rgpc_global_ctrl #(.REVISION(REV)) dut (.*);
    rgpc_host_model host (.*);
    task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [19:0] expv();
        logic n;
        logic m0;
        n = !sl;
        m0 = sl && !ka;
        expv = {n ? 2'h0 : {ka, !ka}, n ? port_edid_enable_a : 1'h1, n ? port_edid_enable_b : 1'h1,
                ka, !m0, n && !pd && !hz[0], n && !pd && !hz[1], n && !pd && !hz[2], n && !hz[3],
                !m0 && !pd, n && !pd, n && !pr && !cg && !xg, n && !cg && !xg, sl || !xg,
                sl || !dc, 4'hF};
    endfunction
    // core and receiver clock enables are masked while the crystal gate is set: their source is open
    task automatic chk_outs();
        chk("outputs", {power_mode, edid_en_a, edid_en_b, consumer_control_en,
            interrupt_pads_en, pixel_oe[0], pixel_clock_out_oe, sync_oe, audio_oe[0],
            first_interrupt_pin_oe, pixel_in_en, proc_core_clk_en && !xg,
            receiver_digital_clk_en && !xg, sync_detect_clk_en || sl, ddc_pads_en || sl,
            ring_osc_en || !sl, pixel_oe === {36{pixel_oe[0]}}, audio_oe === {8{audio_oe[0]}},
            sync_in_en === pixel_in_en}, expv());
        chk("enables", {crystal_to_core_en, crystal_to_edid_en, interrupt_ctrl_en,
            consumer_control_pad_en, sync_in_en}, {!sl && !xg, !sl || ka, !sl || ka,
            !sl || ka, !sl && !pd});
    endtask
    task automatic setall();
        host.xfer(1'h1, 8'h0B, {6'h00, cg, xg}, rr);
        host.xfer(1'h1, 8'h0C, {2'h0, sl, 2'h0, pr, 1'h0, pd}, rr);
        host.xfer(1'h1, 8'h10, {7'h00, ka}, rr);
        host.xfer(1'h1, 8'h15, {3'h0, hz, 1'h0}, rr);
        host.xfer(1'h1, 8'h73, {7'h00, dc}, rr);
        chk_outs();
    endtask
    task automatic rdc(input logic [7:0] a, m, input logic [8:0] e);
        host.xfer(1'h0, a, 8'h00, rr);
        chk("read", {11'h000, rr & {1'h1, m}}, {11'h000, e});
    endtask
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        sys_rst = 1'h1;
        port_edid_enable_a = 1'h0;
        port_edid_enable_b = 1'h1;
        void'($urandom(34854));
        repeat (20) @(posedge clk_sys);
        #1;
        sys_rst = 1'h0;
        {sl, ka, pd, pr, cg, xg, dc, hz} = 11'h40F;
        chk_outs();
        repeat (3) @(posedge clk_sys);
        rdc(8'h0C, 8'h25, 9'h120);
        rdc(8'h15, 8'h1E, 9'h11E);
        host.xfer(1'h1, 8'hEA, 8'h00, rr);
        rdc(8'hEA, 8'hFF, {1'h1, REV[15:8]});
        rdc(8'hEB, 8'hFF, {1'h1, REV[7:0]});
        rdc(8'h42, 8'hFF, 9'h000);
        // first two passes: everything open, then only the pads switched off
        for (int i = 0; i < 40; i++) begin
            {sl, ka, pd, pr, cg, xg, dc, hz} = 11'($urandom);
            {port_edid_enable_a, port_edid_enable_b} = 2'($urandom);
            if (i < 2) {sl, ka, pd, pr, cg, xg, dc, hz} = {2'h0, i[0], 8'h00};
            setall();
        end
        {sl, ka, pd, pr, cg, xg, dc, hz} = 11'h200;
        setall();
        host.xfer(1'h1, 8'hFF, 8'h80, rr);
        @(posedge clk_sys);
        #1;
        {sl, ka, pd, pr, cg, xg, dc, hz} = 11'h40F;
        chk_outs();
        rdc(8'hFF, 8'hFF, 9'h100);
        // reset again in mid-run with the bus drivers opened up
        host.xfer(1'h1, 8'h15, 8'h00, rr);
        sys_rst = 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        sys_rst = 1'h0;
        chk_outs();
        rdc(8'h15, 8'h1E, 9'h11E);
        finish_test();
    end
endmodule
